/* ptbi_pkg.sv */
// package: register map, field layout and divider tap tables
`default_nettype none
package ptbi_pkg;
  // ----------------------------------------------------------------
  // register map (printed offsets are indexes, byte address = 4*index)
  // ----------------------------------------------------------------
  localparam logic [7:0]  PTBI_IDX_CTRL    = 8'h39;
  localparam logic [7:0]  PTBI_IDX_SRC     = 8'h3a;
  localparam logic [7:0]  PTBI_IDX_STATUS  = 8'h3b;
  localparam logic [7:0]  PTBI_CTRL_RESET  = 8'h00;
  localparam logic        PTBI_SRC_RESET   = 1'b0;
  // control register fields
  localparam int          PTBI_EN_BIT      = 3;
  localparam int          PTBI_SEL_LSB     = 0;
  localparam int          PTBI_SEL_W       = 3;
  // source register and status register fields
  localparam int          PTBI_SRC_BIT     = 0;
  localparam int          PTBI_STAT_TAP    = 0;
  localparam int          PTBI_STAT_FSRC   = 1;
  // ----------------------------------------------------------------
  // divider exponents per select code, code 0 in the low slot
  // ----------------------------------------------------------------
  localparam int          PTBI_GEAR_W      = 22;
  localparam int          PTBI_LF_W        = 15;
  localparam logic [7:0][4:0] PTBI_GEAR_EXP =
    {5'd8, 5'd10, 5'd11, 5'd12, 5'd13, 5'd15, 5'd20, 5'd22};
  // zero marks the reserved code
  localparam logic [7:0][4:0] PTBI_LF_EXP =
    {5'd0, 5'd3, 5'd4, 5'd5, 5'd6, 5'd8, 5'd13, 5'd15};
  // highest code usable in slow mode
  localparam logic [2:0]  PTBI_SLOW_MAX    = 3'h1;
endpackage
`default_nettype wire

/* ptbi_chain_if.sv */
// interface: advance strobe and count of one divider chain
`default_nettype none
interface ptbi_chain_if #(parameter int W = 22);
  logic         adv;
  logic [W-1:0] count;
  modport chain (input adv, output count);
  modport user  (output adv, input count);
endinterface
`default_nettype wire

/* ptbi_chain.sv */
// module: free-running binary divider chain
`default_nettype none
module ptbi_chain (
  input wire logic  pclk,
  input wire logic  presetn,
  ptbi_chain_if.chain ch
);
  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // never cleared by the enable bit, only by reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ch.count <= '0;
    else if (ch.adv)
      ch.count <= ch.count + 1'b1;  // RULE8
  end
endmodule
`default_nettype wire

/* ptbi_top.sv */
// module: periodic time base tick generator with apb registers
//
// Summary of operation
// RULE1: enable low means no tick requests
// RULE2: one request per falling edge of tap
// RULE3: gear source taps 2^22 down to 2^8
// RULE4: low-frequency taps 2^15 to 2^3, 111 reserved
// RULE5: slow modes allow only codes 000, 001
// RULE6: stop entry clears enable, keeps select
// RULE7: software changes select only while disabled
// RULE8: divider runs regardless of enable bit
// RULE9: first request at next falling edge
// RULE10: low-frequency clock resynchronised, timing jitters
// RULE11: switch normal/slow modes only while disabled
// RULE12: control bits 7..4 read as zero
// RULE13: software enables interrupt controller bits too
// RULE14: provides periodic time base interrupt request
// RULE15: synchronous edge detect, single-cycle pulse
//
// The implementer's own choice: register access over APB.
`default_nettype none
module ptbi_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output logic                   pready,
  output var  logic              pslverr,
  input  wire logic              low_frequency_clock,
  input  wire logic              mode_slow,
  input  wire logic              mode_stop,
  output var  logic              tick_interrupt_request
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                             tick_request_enable;
  logic [ptbi_pkg::PTBI_SEL_W-1:0]  tick_frequency_select;
  logic                             divider_source_select;
  logic                             lf_s1;
  logic                             lf_s2;
  logic                             lf_s3;
  logic                             stop_q;
  logic                             stop_entry;
  logic                             use_lf;
  logic [4:0]                       gear_exp;
  logic [4:0]                       lf_exp;
  logic                             tap;
  logic                             tap_q;
  logic                             tap_fall;
  logic                             wr_en;
  logic                             rd_setup;
  logic [7:0]                       idx;
  logic                             hit_ctrl;
  logic                             hit_src;
  logic                             hit_stat;
  logic [31:0]                      next_rdata;
  logic                             next_err;

  ptbi_chain_if #(.W(ptbi_pkg::PTBI_GEAR_W)) gear_if ();
  ptbi_chain_if #(.W(ptbi_pkg::PTBI_LF_W))   lf_if ();

  // ----------------------------------------------------------------
  // low-frequency clock synchroniser and edge strobe
  // ----------------------------------------------------------------
  // the pin is far slower than pclk so a rising edge is one clean strobe
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lf_s1 <= 1'b0;
      lf_s2 <= 1'b0;
      lf_s3 <= 1'b0;
    end
    else
    begin
      lf_s1 <= low_frequency_clock;
      lf_s2 <= lf_s1;
      lf_s3 <= lf_s2;
    end
  end

  // resynchronising to pclk costs up to one period of jitter
  assign lf_if.adv   = lf_s2 & ~lf_s3;  // RULE10
  assign gear_if.adv = 1'b1;            // gear clock is pclk itself

  // ----------------------------------------------------------------
  // divider chains
  // ----------------------------------------------------------------
  ptbi_chain u_gear_chain (
    .pclk    (pclk),
    .presetn (presetn),
    .ch      (gear_if)
  );

  ptbi_chain u_lf_chain (
    .pclk    (pclk),
    .presetn (presetn),
    .ch      (lf_if)
  );

  // ----------------------------------------------------------------
  // tap selection
  // ----------------------------------------------------------------
  // slow mode always runs from the low-frequency chain
  assign use_lf   = mode_slow | divider_source_select;
  assign gear_exp = ptbi_pkg::PTBI_GEAR_EXP[tick_frequency_select];
  assign lf_exp   = ptbi_pkg::PTBI_LF_EXP[tick_frequency_select];

  // reserved codes hold the tap low, so they never produce a request
  always_comb
  begin
    tap = 1'b0;
    if (!use_lf)
      tap = gear_if.count[gear_exp - 5'd1];  // RULE3
    else if (mode_slow &&
             tick_frequency_select > ptbi_pkg::PTBI_SLOW_MAX)
      tap = 1'b0;  // RULE5
    else if (lf_exp != 5'd0)
      tap = lf_if.count[4'(lf_exp - 5'd1)];  // RULE4
  end

  // ----------------------------------------------------------------
  // falling edge detect and request pulse
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tap_q <= 1'b0;
    else
      tap_q <= tap;  // RULE9
  end

  assign tap_fall = tap_q & ~tap;  // RULE15

  // edge history runs while disabled, so the first request comes at
  // the very next fall and that first interval may be short
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_interrupt_request <= 1'b0;
    else
      tick_interrupt_request <= tap_fall & tick_request_enable;  // RULE2
  end

  // ----------------------------------------------------------------
  // stop mode entry
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stop_q <= 1'b0;
    else
      stop_q <= mode_stop;
  end

  assign stop_entry = mode_stop & ~stop_q;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign idx      = paddr[9:2];
  assign pready   = psel & penable;  // zero wait states

  always_comb
  begin
    hit_ctrl = 1'b0;
    hit_src  = 1'b0;
    hit_stat = 1'b0;
    if (paddr[1:0] != 2'b00 || paddr[ADDR_W-1:10] != '0)
      hit_ctrl = 1'b0;
    else if (idx == ptbi_pkg::PTBI_IDX_CTRL)
      hit_ctrl = 1'b1;
    else if (idx == ptbi_pkg::PTBI_IDX_SRC)
      hit_src = 1'b1;
    else if (idx == ptbi_pkg::PTBI_IDX_STATUS)
      hit_stat = 1'b1;
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // stop entry wins over a write in the same cycle: stop must leave
  // the generator disabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_request_enable   <=
        ptbi_pkg::PTBI_CTRL_RESET[ptbi_pkg::PTBI_EN_BIT];
      tick_frequency_select <= ptbi_pkg::PTBI_CTRL_RESET[2:0];
    end
    else
    begin
      if (wr_en && hit_ctrl)
      begin
        tick_request_enable   <= pwdata[ptbi_pkg::PTBI_EN_BIT];  // RULE1
        tick_frequency_select <= pwdata[2:0];
      end
      if (stop_entry)
        tick_request_enable <= 1'b0;  // RULE6
    end
  end

  // source register: clock source for the normal modes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      divider_source_select <= ptbi_pkg::PTBI_SRC_RESET;
    else if (wr_en && hit_src)
      divider_source_select <= pwdata[ptbi_pkg::PTBI_SRC_BIT];
  end

  // ----------------------------------------------------------------
  // read data, registered in the setup phase
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    if (hit_ctrl)
    begin
      next_rdata[ptbi_pkg::PTBI_EN_BIT] = tick_request_enable;  // RULE12
      next_rdata[2:0] = tick_frequency_select;
    end
    else if (hit_src)
      next_rdata[ptbi_pkg::PTBI_SRC_BIT] = divider_source_select;
    else if (hit_stat)
    begin
      next_rdata[ptbi_pkg::PTBI_STAT_TAP]  = tap;
      next_rdata[ptbi_pkg::PTBI_STAT_FSRC] = use_lf;
    end
    else
      next_err = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (rd_setup)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
      pslverr <= next_err;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_disabled_no_req: assert property (  // RULE1
    !$past(tick_request_enable) |-> !tick_interrupt_request)
    else $error("request while disabled");

  a_req_on_fall: assert property (  // RULE2
    (tick_request_enable && tap_q && !tap) |=> tick_interrupt_request)
    else $error("falling tap edge gave no request");

  a_req_has_cause: assert property (  // RULE14
    tick_interrupt_request |-> $past(tap_fall))
    else $error("request without a tap edge");

  a_gear_tap: assert property (  // RULE3
    (!mode_slow && !divider_source_select) |->
      tap == gear_if.count[gear_exp - 5'd1])
    else $error("wrong gear tap");

  a_lf_reserved: assert property (  // RULE4
    (use_lf && tick_frequency_select == 3'h7) |-> !tap)
    else $error("reserved code drives tap");

  a_slow_codes: assert property (  // RULE5
    (mode_slow && tick_frequency_select > 3'h1) |-> !tap)
    else $error("slow mode reserved code drives tap");

  a_stop_clears: assert property (  // RULE6
    stop_entry |=> !tick_request_enable &&
      tick_frequency_select == $past(tick_frequency_select))
    else $error("stop entry did not clear enable");

  a_chain_free: assert property (  // RULE8
    $rose(tick_request_enable) |->
      gear_if.count == $past(gear_if.count) + 1'b1)
    else $error("divider restarted on enable");

  a_lf_strobe: assert property (  // RULE10
    lf_if.adv |=> !lf_if.adv)
    else $error("low-frequency strobe longer than one cycle");

  a_pulse_single: assert property (  // RULE15
    tick_interrupt_request |=> !tick_interrupt_request)
    else $error("request pulse longer than one cycle");

  a_ctrl_upper_zero: assert property (  // RULE12
    (pready && hit_ctrl && !pwrite) |-> prdata[31:4] == 28'h000_0000)
    else $error("control upper bits not zero");

  c_gear_request: cover property (
    !use_lf && tick_interrupt_request);
  c_lf_request: cover property (
    use_lf && tick_interrupt_request);
  c_stop_while_on: cover property (
    stop_entry && tick_request_enable);
  c_unmapped: cover property (
    pready && pslverr);
endmodule
`default_nettype wire

/* ptbi_tb_top.sv */
// testbench: periodic time base tick generator driven over apb
`default_nettype none
module ptbi_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // signals and constants
  // ----------------------------------------------------------------
  localparam logic [11:0] A_CTRL = {2'b00, ptbi_pkg::PTBI_IDX_CTRL, 2'b00};
  localparam logic [11:0] A_SRC  = {2'b00, ptbi_pkg::PTBI_IDX_SRC, 2'b00};
  localparam logic [11:0] A_STAT = {2'b00, ptbi_pkg::PTBI_IDX_STATUS, 2'b00};
  localparam logic [11:0] A_BAD  = 12'h0f0;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        low_frequency_clock = 1'b0;
  logic        mode_slow;
  logic        mode_stop;
  logic        tick_interrupt_request;
  int          n_errors;
  int          checked;
  int          cyc = 0;
  int          last_tick;
  int          lf_div = 0;
  int          gexp [8] = '{22, 20, 15, 13, 12, 11, 10, 8};
  int          lexp [8] = '{15, 13, 8, 6, 5, 4, 3, 0};
  ptbi_top i_dut (
    .pclk                   (pclk),
    .presetn                (presetn),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .low_frequency_clock    (low_frequency_clock),
    .mode_slow              (mode_slow),
    .mode_stop              (mode_stop),
    .tick_interrupt_request (tick_interrupt_request)
  );
  // 50 ns clock
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // cycle count and a low-frequency clock of 8 pclk periods, phase locked
  // so that tick intervals come out exact despite the resynchroniser
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    lf_div <= (lf_div == 3) ? 0 : lf_div + 1;
    if (lf_div == 3)
      low_frequency_clock <= ~low_frequency_clock;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: no pready", $time);
      summarize();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input logic eexp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check(r, exp);
    check({31'd0, e}, {31'd0, eexp});
  endtask
  // waits for a tick pulse; n is the number of edges waited
  task automatic wait_tick(input int bound, output int n);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (tick_interrupt_request !== 1'b1 && n < bound);
    if (tick_interrupt_request !== 1'b1)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: tick missing", $time);
      summarize();
    end
    last_tick = cyc;
  endtask
  task automatic count_ticks(input int cycles, output int cnt);
    cnt = 0;
    repeat (cycles)
    begin
      @(posedge pclk);
      if (tick_interrupt_request === 1'b1)
        cnt++;
    end
  endtask
  // select a code with the enable off, enable, then time one period
  task automatic measure(input logic [2:0] c, input int period);
    int n;
    wr(A_CTRL, {29'd0, c});
    wr(A_CTRL, {28'd0, 1'b1, c});
    wait_tick(period + 50, n);
    @(posedge pclk);
    check({31'd0, tick_interrupt_request}, 32'h0000_0000);
    wait_tick(period + 50, n);
    check(n + 1, period);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int n;
    int t0;
    n_errors = 0;
    checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    mode_slow = 1'b0;
    mode_stop = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, read-zero upper bits, unmapped address
    rd(A_CTRL, 32'h0000_0000, 1'b0);
    rd(A_SRC, 32'h0000_0000, 1'b0);
    wr(A_CTRL, 32'hffff_fff7);
    rd(A_CTRL, 32'h0000_0007, 1'b0);
    rd(A_BAD, 32'h0000_0000, 1'b1);
    count_ticks(600, n);
    check(n, 0);
    // first tick comes sooner than a full period; the controller's own
    // enable bits lie outside this block
    wr(A_CTRL, 32'h0000_000f);
    wait_tick(300, n);
    check({31'd0, n <= 256}, 32'h0000_0001);
    // gear taps for the codes that fit the run time
    for (int c = 7; c >= 3; c--)
      measure(3'(c), 1 << gexp[c]);
    // re-enabling keeps the divider phase; select changes only while off
    wr(A_CTRL, 32'h0000_0007);
    wr(A_CTRL, 32'h0000_000f);
    wait_tick(300, n);
    t0 = last_tick;
    wr(A_CTRL, 32'h0000_0007);
    repeat (100) @(posedge pclk);
    wr(A_CTRL, 32'h0000_000f);
    wait_tick(300, n);
    check((last_tick - t0) % 256, 0);
    // stop entry clears the enable and keeps the select
    mode_stop <= 1'b1;
    rd(A_CTRL, 32'h0000_0007, 1'b0);
    count_ticks(600, n);
    check(n, 0);
    mode_stop <= 1'b0;
    // low-frequency source taps, then the reserved code
    wr(A_SRC, 32'h0000_0001);
    rd(A_SRC, 32'h0000_0001, 1'b0);
    // status: low-frequency chain in use, reserved code holds tap low
    rd(A_STAT, 32'h0000_0002, 1'b0);
    for (int c = 6; c >= 2; c--)
      measure(3'(c), 8 << lexp[c]);
    wr(A_CTRL, 32'h0000_0007);
    wr(A_CTRL, 32'h0000_000f);
    count_ticks(1200, n);
    check(n, 0);
    // slow mode refuses codes above one
    wr(A_CTRL, 32'h0000_0002);
    mode_slow <= 1'b1;
    wr(A_CTRL, 32'h0000_000a);
    count_ticks(4500, n);
    check(n, 0);
    summarize();
  end
endmodule
`default_nettype wire
